// File: logic/fsps_pkg.sv
// Constants for the flash self-program sequencer.
// Assumes a 25 MHz system clock and a 32-word page flash.
package fsps_pkg;
  // Control register bit positions
  localparam int CTL_SPE   = 0;
  localparam int CTL_ERS   = 1;
  localparam int CTL_WRT   = 2;
  localparam int CTL_LFS   = 3;
  localparam int CTL_RRE   = 4;
  localparam int CTL_IE    = 7;
  // Command patterns in the low five bits
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LFRD  = 5'h09;
  localparam logic [4:0] CMD_RRE   = 5'h11;
  // Pointer split
  localparam int PTR_W     = 16;
  localparam int WORD_W    = 5;
  localparam int PAGE_W    = PTR_W - 1 - WORD_W;
  localparam int PAGE_WORDS = 32;
  // Lock/fuse read addresses
  localparam logic [15:0] ADR_FLB  = 16'h0000;
  localparam logic [15:0] ADR_LOCK = 16'h0001;
  localparam logic [15:0] ADR_EFB  = 16'h0002;
  localparam logic [15:0] ADR_FHB  = 16'h0003;
  // Command windows
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  // Flash operation time
  localparam int CLK_HZ       = 25000000;
  localparam int FLASH_OP_US  = 4500;
  localparam int FLASH_OP_CYC = (FLASH_OP_US * (CLK_HZ / 1000000));
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} fsps_state_t;
endpackage

// File: logic/fsps_buf_if.sv
// Carrier between the sequencer and its page buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface fsps_buf_if;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [15:0] wr_data;
  logic        clr;
  logic [4:0]  rd_addr;
  logic [15:0] rd_data;
  logic        rd_valid;
  modport seq (output wr_en, output wr_addr, output wr_data, output clr, output rd_addr,
               input rd_data, input rd_valid);
  modport mem (input wr_en, input wr_addr, input wr_data, input clr, input rd_addr,
               output rd_data, output rd_valid);
endinterface

// File: logic/fsps_page_buf.sv
// Temporary page buffer with per-word valid bits.
// Assumes clk and asynchronous active-low reset.
`timescale 1ns/1ps
module fsps_page_buf
  import fsps_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Sequencer side
  fsps_buf_if.mem   bif
);
  logic [15:0]           mem_reg [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] vld_reg;
  logic [15:0]           rd_reg;
  logic                  rdv_reg;

  always_ff @(posedge clk)
  begin
    if (bif.wr_en)
      mem_reg[bif.wr_addr] <= bif.wr_data;
    rd_reg <= mem_reg[bif.rd_addr];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vld_reg <= '0;
      rdv_reg <= 1'b0;
    end
    else
    begin
      rdv_reg <= vld_reg[bif.rd_addr] & ~bif.clr;
      if (bif.clr)
        vld_reg <= '0;
      else if (bif.wr_en)
        vld_reg[bif.wr_addr] <= 1'b1;
    end
  end

  assign bif.rd_data  = rd_reg;
  assign bif.rd_valid = rdv_reg;
endmodule

// File: logic/fsps_seq.sv
// Flash self-program sequencer: command decode, page buffer control,
// erase/write timing, lock/fuse readback.
// Assumes the core drives one-cycle write, store and load strobes.
// Summary of operation
// - Erase pattern then store within four cycles erases a page.
// - Erase takes the page only from the page index field.
// - Core stalls for the whole erase or write.
// - Load pattern then store places data pair into buffer word.
// - Buffer clears after page write, re-enable write, and reset.
// - EEPROM write during loading discards loaded words.
// - Write pattern then store programs buffer into indexed page.
// - Pointer low bits pick word in page, high bits pick page.
// - Load instructions address bytes by pointer bit 0; buffer ignores it.
// - EEPROM write blocks programming commands and lock/fuse reads.
// - Lock address plus read select and enable returns lock bits.
// - Read select and enable self-clear after read or timeout.
// - With both bits clear, loads read program memory.
// - Pointer value selects low, high or extended configuration byte.
// - Programmed bits read zero, unprogrammed read one.
// - A flash write under way at reset completes anyway.
// - Store instructions accepted from any flash location.
// - Buffer words load in any order, before or after erase.
// - Control bits: enable 0, erase 1, write 2, select 3, re-enable 4, irq 7.
// - Undefined low five bit combinations have no effect.
// - Enable bit stays set through erase or write.
// - Store-ready irq asserted while enable clear, irq enabled, global set, and no EEPROM write busy.
`timescale 1ns/1ps
module fsps_seq
  import fsps_pkg::*;
#(
  parameter int OP_CYCLES = FLASH_OP_CYC
)
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Control register access
  input  wire logic               ctl_wr,
  input  wire logic [7:0]         ctl_wdata,
  output logic [7:0]              program_store_control_reg,
  // Core instructions
  input  wire logic               store_req,
  input  wire logic               load_req,
  input  wire logic [PTR_W-1:0]   ptr,
  input  wire logic [15:0]        data_register_pair,
  output logic                    cpu_stall,
  output logic                    load_valid,
  output logic [7:0]              load_data,
  // Program memory read port
  output logic [PTR_W-2:0]        pm_rd_addr,
  input  wire logic [15:0]        pm_rd_data,
  // Flash array programming
  output logic                    flash_erase,
  output logic                    flash_write,
  output logic [PAGE_W-1:0]       flash_page,
  output logic [WORD_W-1:0]       flash_word,
  output logic [15:0]             flash_wdata,
  output logic                    flash_wvalid,
  // EEPROM and interrupt
  input  wire logic               eeprom_write_busy,
  input  wire logic               global_irq_en,
  output logic                    store_ready_irq,
  // Configuration bytes
  input  wire logic [7:0]         lock_bits,
  input  wire logic [7:0]         config_low_byte,
  input  wire logic [7:0]         config_high_byte,
  input  wire logic [7:0]         config_extended_byte
);
  localparam logic [22:0] OP_LAST = 23'(OP_CYCLES - 1);

  fsps_buf_if bif ();
  fsps_page_buf u_buf
  (
    .clk     (clk),
    .reset_n (reset_n),
    .bif     (bif)
  );

  // ****************************************
  // Control register and windows
  // ****************************************
  fsps_state_t         state_reg, state_next;
  logic [4:0]          cmd_reg;
  logic                ie_reg;
  logic [2:0]          win_reg;
  logic [22:0]         cnt_reg;
  logic [PAGE_W-1:0]   page_reg;
  logic                loading_reg;
  logic                load_valid_reg;
  logic [7:0]          load_data_reg;
  logic                lf_pend_reg;

  wire logic [4:0]  cmd_in     = ctl_wdata[4:0];
  wire logic        cmd_legal  = (cmd_in == CMD_LOAD) || (cmd_in == CMD_ERASE) || (cmd_in == CMD_WRITE) ||
                                 (cmd_in == CMD_LFRD) || (cmd_in == CMD_RRE);
  wire logic        busy       = (state_reg != ST_IDLE);
  wire logic        cmd_take   = ctl_wr && !busy && !eeprom_write_busy && cmd_legal;
  wire logic        armed      = cmd_reg[CTL_SPE] && !busy;
  wire logic        st_hit     = armed && store_req;
  wire logic        do_erase   = st_hit && (cmd_reg == CMD_ERASE);
  wire logic        do_write   = st_hit && (cmd_reg == CMD_WRITE);
  wire logic        do_load    = st_hit && (cmd_reg == CMD_LOAD);
  wire logic        lf_mode    = armed && (cmd_reg == CMD_LFRD);
  wire logic        do_lfrd    = lf_mode && load_req && (win_reg < LOAD_WIN) && !eeprom_write_busy;
  wire logic        win_end    = (win_reg == STORE_WIN - 3'h1) ||
                                 (lf_mode && win_reg == LOAD_WIN - 3'h1);
  wire logic        op_done    = busy && (cnt_reg == OP_LAST);
  wire logic [PAGE_W-1:0] ptr_page = ptr[PTR_W-1 -: PAGE_W];
  wire logic [WORD_W-1:0] ptr_word = ptr[WORD_W:1];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_reg <= '0;
      ie_reg  <= 1'b0;
      win_reg <= '0;
    end
    else
    begin
      if (ctl_wr)
        ie_reg <= ctl_wdata[CTL_IE];
      if (cmd_take)
      begin
        cmd_reg <= (cmd_in == CMD_RRE) ? 5'h00 : cmd_in;
        win_reg <= '0;
      end
      else if (op_done || do_load || do_lfrd || (armed && !do_erase && !do_write && (win_end || st_hit)))
        cmd_reg <= '0;
      else if (armed)
        win_reg <= win_reg + 3'h1;
    end
  end

  // ****************************************
  // Erase / write sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  state_next = do_erase ? ST_ERASE : (do_write ? ST_WRITE : ST_IDLE);
      ST_ERASE: state_next = op_done ? ST_IDLE : ST_ERASE;
      ST_WRITE: state_next = op_done ? ST_IDLE : ST_WRITE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (state_reg == ST_IDLE && (do_erase || do_write))
      page_reg <= ptr_page;
  end

  // Running operation outlives reset; parks only when idle
  always_ff @(posedge clk)
  begin
    if (reset_n || busy)
    begin
      state_reg <= state_next;
      cnt_reg   <= (busy && !op_done) ? cnt_reg + 23'h1 : 23'h0;
    end
    else
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 23'h0;
    end
  end

  assign cpu_stall   = busy;
  assign flash_erase = (state_reg == ST_ERASE);
  assign flash_write = (state_reg == ST_WRITE);
  assign flash_page  = page_reg;
  // Write streams buffer words during first cycles
  assign flash_word  = cnt_reg[WORD_W-1:0] - 5'h2;
  assign flash_wdata = bif.rd_data;
  assign flash_wvalid = flash_write && (cnt_reg >= 23'h2) && (cnt_reg < 23'(PAGE_WORDS + 2)) && bif.rd_valid;

  // ****************************************
  // Page buffer control
  // ****************************************
  // Any word, any order
  assign bif.wr_en   = do_load;
  assign bif.wr_addr = ptr_word;
  assign bif.wr_data = data_register_pair;
  // One word ahead of flash_word; buffer read is registered
  assign bif.rd_addr = cnt_reg[WORD_W-1:0] - 5'h1;
  assign bif.clr     = (flash_write && op_done) || (cmd_take && cmd_in == CMD_RRE) ||
                       (loading_reg && eeprom_write_busy);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      loading_reg <= 1'b0;
    else if (bif.clr)
      loading_reg <= 1'b0;
    else if (do_load)
      loading_reg <= 1'b1;
  end

  // ****************************************
  // Load instruction data path
  // ****************************************
  assign pm_rd_addr = ptr[PTR_W-1:1];

  wire logic [7:0] lf_sel  = (ptr == ADR_FLB)  ? config_low_byte :
                             (ptr == ADR_LOCK) ? lock_bits :
                             (ptr == ADR_EFB)  ? config_extended_byte :
                             (ptr == ADR_FHB)  ? config_high_byte : 8'hff;
  wire logic [7:0] pm_byte = ptr[0] ? pm_rd_data[15:8] : pm_rd_data[7:0];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lf_pend_reg    <= 1'b0;
      load_valid_reg <= 1'b0;
      load_data_reg  <= '0;
    end
    else
    begin
      lf_pend_reg    <= do_lfrd;
      load_valid_reg <= load_req && !do_lfrd && !busy;
      if (do_lfrd)
        load_data_reg <= lf_sel;
      else if (load_req && !busy)
        load_data_reg <= pm_byte;
    end
  end

  assign load_valid = lf_pend_reg || load_valid_reg;
  assign load_data  = load_data_reg;

  assign program_store_control_reg = {ie_reg, 2'b00, 1'b0, cmd_reg[3:1], cmd_reg[0] | busy};
  assign store_ready_irq = ie_reg && global_irq_en && !(cmd_reg[CTL_SPE] || busy) && !eeprom_write_busy;

  // ****************************************
  // Checks
  // ****************************************
  property p_erase_start;
    @(posedge clk) disable iff (!reset_n) do_erase |=> flash_erase && cpu_stall;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("Erase did not start");
  property p_write_start;
    @(posedge clk) disable iff (!reset_n) do_write |=> flash_write;
  endproperty
  a_write_start: assert property (p_write_start) else $error("Write did not start");
  property p_stall;
    @(posedge clk) disable iff (!reset_n) (flash_erase || flash_write) |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("Core not stalled");
  property p_enable_held;
    @(posedge clk) disable iff (!reset_n) busy |-> program_store_control_reg[CTL_SPE];
  endproperty
  a_enable_held: assert property (p_enable_held) else $error("Enable dropped during operation");
  property p_ee_block;
    @(posedge clk) disable iff (!reset_n) (ctl_wr && eeprom_write_busy && !armed && !busy) |=> !cmd_reg[CTL_SPE];
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("Command taken during EEPROM write");
  property p_timeout;
    @(posedge clk) disable iff (!reset_n) (cmd_take && cmd_in != CMD_RRE) ##1 (!store_req && !load_req)[*4]
      |=> !cmd_reg[CTL_SPE] || busy;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Enable did not time out");
  property p_illegal;
    @(posedge clk) disable iff (!reset_n) (ctl_wr && !cmd_legal && !busy && !armed) |=> (cmd_reg == 5'h00);
  endproperty
  a_illegal: assert property (p_illegal) else $error("Illegal pattern took effect");
  property p_lfrd;
    @(posedge clk) disable iff (!reset_n) (do_lfrd && ptr == ADR_LOCK) |=> load_valid && load_data == lock_bits;
  endproperty
  a_lfrd: assert property (p_lfrd) else $error("Lock bits not returned");
  property p_op_held;
    @(posedge clk) (busy && !op_done) |=> busy;
  endproperty
  a_op_held: assert property (p_op_held) else $error("Flash operation cut short");
  c_erase: cover property (@(posedge clk) disable iff (!reset_n) do_erase);
  c_write: cover property (@(posedge clk) disable iff (!reset_n) do_write);
  c_load:  cover property (@(posedge clk) disable iff (!reset_n) do_load);
  c_lfrd:  cover property (@(posedge clk) disable iff (!reset_n) do_lfrd);
endmodule

// File: tb/fsps_core_model.sv
// Core model: control writes, store and load strobes, program memory.
// Assumes the sequencer samples on the rising clk edge; drives 1 ns after.
`timescale 1ns/1ps
module fsps_core_model
  import fsps_pkg::*;
(
  // Clock and stall
  input  wire logic        clk,
  input  wire logic        cpu_stall,
  // Instruction side
  output logic             ctl_wr,
  output logic [7:0]       ctl_wdata,
  output logic             store_req,
  output logic             load_req,
  output logic [15:0]      ptr,
  output logic [15:0]      data_register_pair,
  // Program memory
  input  wire logic [14:0] pm_rd_addr,
  output logic [15:0]      pm_rd_data
);
  // ****************
  // Core behaviour
  // ****************
  initial
  begin
    {ctl_wr, store_req, load_req} = 3'h0;
    ctl_wdata = 8'h00;
    ptr = 16'h0000;
    data_register_pair = 16'h0000;
  end
  assign pm_rd_data = {~pm_rd_addr[7:0], pm_rd_addr[7:0]};
  // Halted core issues no control writes; instr does not wait out the stall
  task automatic ctl(input logic [7:0] pat);
    while (cpu_stall === 1'b1)
      @(posedge clk);
    @(posedge clk);
    #1;
    ctl_wr = 1'b1;
    ctl_wdata = pat;
    @(posedge clk);
    #1;
    ctl_wr = 1'b0;
    ctl_wdata = ~pat;
  endtask
  // Callers keep words distinct, pages clean
  task automatic instr(input logic st, input logic ld, input logic [15:0] p, input logic [15:0] d);
    @(posedge clk);
    #1;
    ptr = p;
    data_register_pair = d;
    store_req = st;
    load_req = ld;
    @(posedge clk);
    #1;
    store_req = 1'b0;
    load_req = 1'b0;
    data_register_pair = ~d;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes a shortened flash operation of OP cycles.
`timescale 1ns/1ps
module testbench
  import fsps_pkg::*;
();
  localparam int OP = 40;
  typedef struct packed {logic [7:0] cmd; logic [15:0] p; logic [7:0] e;} fsps_row_t;
  logic        clk, reset_n, ctl_wr, store_req, load_req, cpu_stall, load_valid;
  logic        flash_erase, flash_write, flash_wvalid, eeprom_write_busy, global_irq_en, store_ready_irq;
  logic [7:0]  ctl_wdata, program_store_control_reg, load_data, lock_bits;
  logic [7:0]  config_low_byte, config_high_byte, config_extended_byte;
  logic [15:0] ptr, data_register_pair, pm_rd_data, flash_wdata;
  logic [14:0] pm_rd_addr;
  logic [9:0]  flash_page, pg;
  logic [4:0]  flash_word;
  logic [1:0]  mode;
  logic        en;
  logic [15:0] seen [32];
  int          bad_count, num_checks, wcount, n;
  fsps_row_t rows [7] = '{'{8'h09, 16'h0000, 8'h62}, '{8'h09, 16'h0001, 8'hfc}, '{8'h09, 16'h0002, 8'hf9},
    '{8'h09, 16'h0003, 8'hdf}, '{8'h09, 16'h0004, 8'hff}, '{8'h00, 16'h0013, 8'hf6}, '{8'h00, 16'h0012, 8'h09}};

  fsps_seq #(.OP_CYCLES(OP)) i_dut (.clk, .reset_n, .ctl_wr, .ctl_wdata, .program_store_control_reg,
    .store_req, .load_req, .ptr, .data_register_pair, .cpu_stall, .load_valid, .load_data, .pm_rd_addr,
    .pm_rd_data, .flash_erase, .flash_write, .flash_page, .flash_word, .flash_wdata, .flash_wvalid,
    .eeprom_write_busy, .global_irq_en, .store_ready_irq, .lock_bits, .config_low_byte,
    .config_high_byte, .config_extended_byte);
  fsps_core_model i_core (.clk, .cpu_stall, .ctl_wr, .ctl_wdata, .store_req, .load_req, .ptr,
    .data_register_pair, .pm_rd_addr, .pm_rd_data);

  // ****************
  // Clock, monitor, tasks
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk)
    if (flash_wvalid === 1'b1)
    begin
      wcount++;
      seen[flash_word] = flash_wdata;
    end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Command plus store; records kind, page and stall length
  task automatic op(input logic [7:0] pat, input logic [15:0] p, output int cnt);
    cnt = 0;
    wcount = 0;
    i_core.ctl(pat);
    i_core.instr(1'b1, 1'b0, p, 16'h5555);
    for (int k = 0; k < 4 && cpu_stall !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    mode = {flash_erase, flash_write};
    pg = flash_page;
    en = program_store_control_reg[0];
    while (cpu_stall === 1'b1 && cnt < 200)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic ld(input logic [15:0] p, input logic [15:0] d);
    i_core.ctl(8'h01);
    i_core.instr(1'b1, 1'b0, p, d);
  endtask

  // ****************
  // Test sequence
  // ****************
  initial
  begin
    {reset_n, eeprom_write_busy, global_irq_en} = 3'b001;
    {lock_bits, config_low_byte, config_high_byte, config_extended_byte} = 32'hfc62dff9;
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk({program_store_control_reg, 7'h0, cpu_stall}, 16'h0000);
    foreach (rows[i])
    begin
      if (rows[i].cmd != 8'h00)
        i_core.ctl(rows[i].cmd);
      i_core.instr(1'b0, 1'b1, rows[i].p, 16'h0000);
      chk({7'h0, load_valid, load_data}, {8'h01, rows[i].e});
      @(posedge clk);
      #1;
      chk({8'h0, program_store_control_reg}, 16'h0000);
    end
    // Words out of order, before erase
    ld(16'h0152, 16'h9999);
    ld(16'h0147, 16'hbeef);
    op(8'h03, 16'h017f, n);
    chk({6'h0, pg}, 16'h0005);
    chk({14'h0, mode}, 16'h0002);
    chk({15'h0, en}, 16'h0001);
    chk(16'(n >= OP - 1 && n <= OP + 1), 16'h0001);
    chk({8'h0, program_store_control_reg}, 16'h0000);
    op(8'h05, 16'h0140, n);
    chk({14'h0, mode}, 16'h0001);
    chk({6'h0, pg}, 16'h0005);
    chk(16'(wcount), 16'h0002);
    chk(seen[3], 16'hbeef);
    chk(seen[9], 16'h9999);
    op(8'h05, 16'h0140, n);
    chk(16'(wcount), 16'h0000);
    ld(16'h0142, 16'h1111);
    i_core.ctl(8'h11);
    op(8'h05, 16'h0140, n);
    chk(16'(wcount), 16'h0000);
    ld(16'h0144, 16'h2222);
    eeprom_write_busy = 1'b1;
    op(8'h03, 16'h0140, n);
    chk({14'h0, mode}, 16'h0000);
    eeprom_write_busy = 1'b0;
    op(8'h05, 16'h0140, n);
    chk(16'(wcount), 16'h0000);
    i_core.ctl(8'h03);
    repeat (3) @(posedge clk);
    i_core.instr(1'b1, 1'b0, 16'h0140, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, cpu_stall, program_store_control_reg}, 16'h0000);
    // Store on last window cycle, reset mid-erase
    ld(16'h0146, 16'h3333);
    i_core.ctl(8'h03);
    repeat (2) @(posedge clk);
    i_core.instr(1'b1, 1'b0, 16'h0180, 16'h0000);
    chk({14'h0, flash_erase, cpu_stall}, 16'h0003);
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk({8'h0, program_store_control_reg}, 16'h0001);
    repeat (30) @(posedge clk);
    #1;
    chk({14'h0, flash_erase, cpu_stall}, 16'h0003);
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0, flash_erase, cpu_stall}, 16'h0000);
    op(8'h05, 16'h0180, n);
    chk(16'(wcount), 16'h0000);
    i_core.ctl(8'h07);
    chk({8'h0, program_store_control_reg}, 16'h0000);
    i_core.ctl(8'h80);
    chk({7'h0, store_ready_irq, program_store_control_reg}, 16'h0180);
    global_irq_en = 1'b0;
    #1;
    chk({15'h0, store_ready_irq}, 16'h0000);
    test_done();
  end
  initial
  begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule
